// ---- design/vcb_consts.vh ----
// constants for the serial bridge uart
`ifndef VCB_CONSTS_VH
`define VCB_CONSTS_VH
`define VCB_CLK_HZ        250000000
`define VCB_BAUD_DEFAULT  115200
`define VCB_BAUD_MIN      9600
`define VCB_BAUD_MAX      921600
// clocks per bit at the default rate, rounded
`define VCB_DIV_DEFAULT   16'h087A
`define VCB_DIV_W         16
`define VCB_DATA_BITS     8
`define VCB_REG_CTRL      4'h0
`define VCB_REG_BAUD      4'h1
`define VCB_REG_STATUS    4'h2
`define VCB_REG_TXDATA    4'h3
`define VCB_REG_RXDATA    4'h4
`define VCB_CTRL_EN       0
`define VCB_CTRL_CTS_EN   1
`define VCB_CTRL_RTS_EN   2
`define VCB_CTRL_RESET    8'h00
`define VCB_ST_TX_BUSY    0
`define VCB_ST_RX_VALID   1
`define VCB_ST_RX_OVR     2
`define VCB_ST_FRM_ERR    3
`define VCB_ST_CTS        4
`endif

// ---- design/vcb_uart.v ----
// serial bridge uart: transmitter, receiver, handshake, register port
`timescale 1ns/1ps
`default_nettype none
`include "vcb_consts.vh"
module vcb_uart #(
  parameter [`VCB_DIV_W-1:0] DIV_RESET = `VCB_DIV_DEFAULT
) (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         vcom_tx,
  input  wire        vcom_rx,
  input  wire        vcom_cts,
  output reg         vcom_rts,
  output reg         vcom_enable
);
  localparam S_IDLE  = 2'h0;
  localparam S_START = 2'h1;
  localparam S_DATA  = 2'h2;
  localparam S_STOP  = 2'h3;

  reg [7:0]            ctrl_r;
  reg [`VCB_DIV_W-1:0] div_r;
  reg [1:0]            rx_sync_r;
  reg [1:0]            cts_sync_r;
  // tx side
  reg [1:0]            tx_st_r;
  reg [`VCB_DIV_W-1:0] tx_cnt_r;
  reg [2:0]            tx_bit_r;
  reg [7:0]            tx_sh_r;
  reg [7:0]            tx_hold_r;
  reg                  tx_pend_r;
  // rx side
  reg [1:0]            rx_st_r;
  reg [`VCB_DIV_W-1:0] rx_cnt_r;
  reg [2:0]            rx_bit_r;
  reg [7:0]            rx_sh_r;
  reg [7:0]            rx_data_r;
  reg                  rx_valid_r;
  // spare slot for the byte already in flight when rts drops
  reg [7:0]            rx_spare_r;
  reg                  rx_spare_ok_r;
  reg                  rx_ovr_r;
  reg                  frm_err_r;

  wire en       = ctrl_r[`VCB_CTRL_EN];
  wire cts_use  = ctrl_r[`VCB_CTRL_CTS_EN];
  wire rts_use  = ctrl_r[`VCB_CTRL_RTS_EN];
  wire rx_in    = rx_sync_r[1];
  wire cts_ok   = ~cts_use | cts_sync_r[1];
  wire rx_pop   = reg_rd & (reg_addr == `VCB_REG_RXDATA);
  wire tx_wr    = reg_wr & (reg_addr == `VCB_REG_TXDATA);
  wire tx_busy  = tx_pend_r | (tx_st_r != S_IDLE);
  wire [`VCB_DIV_W-1:0] half = {1'b0, div_r[`VCB_DIV_W-1:1]};

  function [`VCB_DIV_W-1:0] dec;
    input [`VCB_DIV_W-1:0] v;
    dec = v - {{(`VCB_DIV_W-1){1'b0}}, 1'b1};
  endfunction

  // pin synchronisers
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync_r  <= 2'h3;
      cts_sync_r <= 2'h0;
    end else begin
      rx_sync_r  <= {rx_sync_r[0], vcom_rx};
      cts_sync_r <= {cts_sync_r[0], vcom_cts};
    end
  end

  // control registers
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `VCB_CTRL_RESET;
      div_r  <= DIV_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `VCB_REG_CTRL)
        ctrl_r <= {5'h00, reg_wdata[2:0]};
      if (reg_addr == `VCB_REG_BAUD && reg_wdata[`VCB_DIV_W-1:0] > 16'h0001)
        div_r <= reg_wdata[`VCB_DIV_W-1:0];
    end
  end

  // read port
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `VCB_REG_CTRL:   reg_rdata <= {24'h0, ctrl_r};
        `VCB_REG_BAUD:   reg_rdata <= {16'h0, div_r};
        `VCB_REG_STATUS: reg_rdata <= {27'h0, cts_sync_r[1], frm_err_r, rx_ovr_r,
                                       rx_valid_r, tx_busy};
        `VCB_REG_RXDATA: reg_rdata <= {24'h0, rx_data_r};
        default:         reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // transmitter
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_r   <= S_IDLE;
      tx_cnt_r  <= 16'h0;
      tx_bit_r  <= 3'h0;
      tx_sh_r   <= 8'h0;
      tx_hold_r <= 8'h0;
      tx_pend_r <= 1'b0;
      vcom_tx   <= 1'b1;
    end else begin
      if (tx_wr && !tx_pend_r) begin
        tx_hold_r <= reg_wdata[7:0];
        tx_pend_r <= 1'b1;
      end
      case (tx_st_r)
        S_IDLE: begin
          vcom_tx <= 1'b1;
          if (tx_pend_r && en && cts_ok) begin
            tx_sh_r   <= tx_hold_r;
            tx_pend_r <= 1'b0;
            tx_cnt_r  <= dec(div_r);
            vcom_tx   <= 1'b0;
            tx_st_r   <= S_START;
          end
        end
        S_START, S_DATA: begin
          if (tx_cnt_r == 16'h0) begin
            tx_cnt_r <= dec(div_r);
            vcom_tx  <= tx_sh_r[0];
            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
            if (tx_st_r == S_START) begin
              tx_bit_r <= 3'h0;
              tx_st_r  <= S_DATA;
            end else if (tx_bit_r == 3'h7) begin
              vcom_tx <= 1'b1;
              tx_st_r <= S_STOP;
            end else begin
              tx_bit_r <= tx_bit_r + 3'h1;
            end
          end else begin
            tx_cnt_r <= dec(tx_cnt_r);
          end
        end
        default: begin
          if (tx_cnt_r == 16'h0)
            tx_st_r <= S_IDLE;
          else
            tx_cnt_r <= dec(tx_cnt_r);
        end
      endcase
    end
  end

  // receiver
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_r    <= S_IDLE;
      rx_cnt_r   <= 16'h0;
      rx_bit_r   <= 3'h0;
      rx_sh_r    <= 8'h0;
      rx_data_r  <= 8'h0;
      rx_valid_r <= 1'b0;
      rx_spare_r    <= 8'h00;
      rx_spare_ok_r <= 1'b0;
      rx_ovr_r   <= 1'b0;
      frm_err_r  <= 1'b0;
    end else begin
      if (rx_pop) begin
        rx_valid_r    <= rx_spare_ok_r;
        rx_spare_ok_r <= 1'b0;
        rx_ovr_r      <= 1'b0;
        frm_err_r     <= 1'b0;
        if (rx_spare_ok_r)
          rx_data_r <= rx_spare_r;
      end
      case (rx_st_r)
        S_IDLE: begin
          if (!rx_in) begin
            rx_cnt_r <= half;
            rx_st_r  <= S_START;
          end
        end
        S_START: begin
          if (rx_cnt_r == 16'h0) begin
            rx_cnt_r <= dec(div_r);
            rx_bit_r <= 3'h0;
            rx_st_r  <= rx_in ? S_IDLE : S_DATA;
          end else begin
            rx_cnt_r <= dec(rx_cnt_r);
          end
        end
        S_DATA: begin
          if (rx_cnt_r == 16'h0) begin
            rx_cnt_r <= dec(div_r);
            rx_sh_r  <= {rx_in, rx_sh_r[7:1]};
            if (rx_bit_r == 3'h7)
              rx_st_r <= S_STOP;
            else
              rx_bit_r <= rx_bit_r + 3'h1;
          end else begin
            rx_cnt_r <= dec(rx_cnt_r);
          end
        end
        default: begin
          if (rx_cnt_r == 16'h0) begin
            rx_st_r <= S_IDLE;
            // landing beats a pop in the same cycle
            if (!rx_in) begin
              frm_err_r <= 1'b1;
            end else if (!rx_valid_r || (rx_pop && !rx_spare_ok_r)) begin
              rx_data_r  <= rx_sh_r;
              rx_valid_r <= 1'b1;
            end else if (!rx_spare_ok_r || rx_pop) begin
              rx_spare_r    <= rx_sh_r;
              rx_spare_ok_r <= 1'b1;
            end else begin
              rx_ovr_r <= 1'b1;
            end
          end else begin
            rx_cnt_r <= dec(rx_cnt_r);
          end
        end
      endcase
    end
  end

  // handshake and enable outputs
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vcom_rts    <= 1'b0;
      vcom_enable <= 1'b0;
    end else begin
      vcom_enable <= en;
      vcom_rts    <= rts_use ? (en & ~rx_valid_r) : en;
    end
  end
endmodule
`default_nettype wire

// ---- verification/vcb_uart_assertions.sv ----
// port checker for the serial bridge uart
`timescale 1ns/1ps
`default_nettype none
module vcb_uart_chk (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        vcom_tx,
  input wire logic        vcom_rx,
  input wire logic        vcom_cts,
  input wire logic        vcom_rts,
  input wire logic        vcom_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic ctrl_rts_r;
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n) ctrl_rts_r <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0) ctrl_rts_r <= reg_wdata[2];
  rts_gate_a: assert property (vcom_rts |-> vcom_enable)
    else $error("rts high while disabled");
  tx_start_en_a: assert property ($fell(vcom_tx) |-> vcom_enable)
    else $error("tx moved while disabled");
  en_follow_a: assert property (reg_wr && reg_addr == 4'h0 |->
      ##2 vcom_enable == $past(reg_wdata[0], 2))
    else $error("enable not from ctrl");
  start_len_a: assert property ($fell(vcom_tx) |-> !vcom_tx [*8])
    else $error("start bit too short");
  rts_follow_a: assert property ((!ctrl_rts_r && vcom_enable) [*2] |-> vcom_rts)
    else $error("rts not ready with flow off");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  unmapped_rd_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h4 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  status_hi_a: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[31:5] == 27'h0)
    else $error("status upper bits set");
  cover property ($fell(vcom_tx));
  cover property ($fell(vcom_rts) && vcom_enable);
  cover property ($past(reg_rd) && $past(reg_addr) == 4'h4);
endmodule
bind vcb_uart vcb_uart_chk u_chk (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .vcom_tx, .vcom_rx, .vcom_cts, .vcom_rts, .vcom_enable);
`default_nettype wire

// ---- verification/vcb_ctrl_model.sv ----
// board controller model: frame receiver and sender
`timescale 1ns/1ps
`default_nettype none
module vcb_ctrl_model #(parameter int BIT_NS = 64) (
  input  wire logic tx,
  input  wire logic rts,
  output var  logic rx,
  output var  logic cts
);
  logic [7:0] rx_byte;
  int         rx_cnt = 0;
  logic       powered = 1'b1;
  logic       hs_rts = 1'b0;
  logic       hs_cts = 1'b0;
  logic       buf_full = 1'b0;
  initial rx = 1'b1;
  // cts held low only in rts mode with a full buffer
  always_comb cts = !(hs_rts && buf_full);
  // one capture log stands for the single active host path
  always @(negedge tx) begin
    #(BIT_NS / 2);
    if (!tx && powered) begin
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        rx_byte[i] = tx;
      end
      #(BIT_NS);
      if (tx) rx_cnt++;
    end
  end
  task automatic send(input logic [7:0] b);
    #1;
    wait (powered && (!hs_cts || rts));
    rx = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rx = b[i];
      #(BIT_NS);
    end
    rx = 1'b1;
    #(BIT_NS);
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the serial bridge uart
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic        vcom_tx, vcom_rx, vcom_cts, vcom_rts, vcom_enable;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          n;
  always #2 sys_clk = ~sys_clk;
  vcb_uart #(.DIV_RESET(16'h0010)) u_dut (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .vcom_tx, .vcom_rx, .vcom_cts, .vcom_rts, .vcom_enable);
  vcb_ctrl_model #(.BIT_NS(64)) u_ctrl (.tx(vcom_tx), .rts(vcom_rts), .rx(vcom_rx), .cts(vcom_cts));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic t_reset;
    rd(4'h0); chk("ctrl", d, 32'h0);
    rd(4'h1); chk("baud", d, 32'h10);
    wr(4'h1, 32'h1);
    rd(4'h1); chk("baud low", d, 32'h10);
    wr(4'h1, 32'h20);
    rd(4'h1); chk("baud set", d, 32'h20);
    wr(4'h1, 32'h10);
    rd(4'hF); chk("unmapped", d, 32'h0);
    chk("idle", {vcom_tx, vcom_rts, vcom_enable}, 32'h4);
  endtask
  task automatic t_tx;
    n = u_ctrl.rx_cnt;
    wr(4'h3, 32'hA5);
    rd(4'h2); chk("pending", d, 32'h11);
    repeat (200) @(posedge sys_clk);
    chk("held", u_ctrl.rx_cnt, n);
    wr(4'h0, 32'h1);
    for (int i = 0; i < 400 && u_ctrl.rx_cnt == n; i++) @(posedge sys_clk);
    chk("tx count", u_ctrl.rx_cnt, n + 1);
    chk("tx byte", u_ctrl.rx_byte, 32'hA5);
  endtask
  task automatic t_rx;
    u_ctrl.send(8'h3C);
    rd(4'h2); chk("status", d, 32'h12);
    chk("rts on", vcom_rts, 32'h1);
    rd(4'h4); chk("rx byte", d, 32'h3C);
    wr(4'h0, 32'h5);
    u_ctrl.send(8'h81);
    repeat (2) @(posedge sys_clk);
    chk("rts full", vcom_rts, 32'h0);
    u_ctrl.send(8'h42);
    u_ctrl.send(8'hE7);
    rd(4'h2); chk("overrun", d, 32'h16);
    rd(4'h4); chk("rx byte2", d, 32'h81);
    repeat (2) @(posedge sys_clk);
    chk("rts spare", vcom_rts, 32'h0);
    rd(4'h4); chk("rx byte3", d, 32'h42);
    rd(4'h2); chk("drained", d, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk("rts free", vcom_rts, 32'h1);
  endtask
  task automatic t_cts;
    n = u_ctrl.rx_cnt;
    u_ctrl.hs_rts <= 1'b1;
    u_ctrl.buf_full <= 1'b1;
    wr(4'h0, 32'h3);
    wr(4'h3, 32'h5A);
    repeat (200) @(posedge sys_clk);
    chk("cts hold", u_ctrl.rx_cnt, n);
    rd(4'h2); chk("cts status", d, 32'h1);
    u_ctrl.buf_full <= 1'b0;
    for (int i = 0; i < 400 && u_ctrl.rx_cnt == n; i++) @(posedge sys_clk);
    chk("cts count", u_ctrl.rx_cnt, n + 1);
    chk("cts byte", u_ctrl.rx_byte, 32'h5A);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_cts();
    report_and_stop();
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
  task automatic report_and_stop;
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
